// File: design/fsep_cfg.svh
`ifndef FSEP_CFG_SVH
`define FSEP_CFG_SVH
// Information memory window and segmenting
`define FSEP_INFO_BASE 16'h1000
`define FSEP_INFO_SEGS 16'h0004
`define FSEP_INFO_SEG_BYTES 16'h0040
// Segment A is the top information segment
`define FSEP_SEG_A_IDX 2'h3
// Main memory segmenting, segment count default
`define FSEP_MAIN_SEG_BYTES 16'h0200
`define FSEP_MAIN_SEGS_DEF 32'h0000_0020
// Calibration records
`define FSEP_OSC_TAG_ADDR 16'h10f6
`define FSEP_OSC_TAG 8'h01
`define FSEP_CONV_TAG_ADDR 16'h10da
`define FSEP_CONV_TAG 8'h08
`define FSEP_EMPTY_TAG 8'hfe
`define FSEP_OSC_PAIR_OFS 16'h0008
`define FSEP_CONV_GAIN_OFS 16'h0002
`define FSEP_CONV_OFFSET_OFS 16'h0004
// Content of an erased word
`define FSEP_ERASED_WORD 16'hffff
`endif

// File: design/fsep_pkg.sv
package fsep_pkg;
    // Commands from either programming source
    typedef enum logic [2:0] {
        CMD_READ,
        CMD_WRITE_BYTE,
        CMD_WRITE_WORD,
        CMD_ERASE_SEG,
        CMD_ERASE_MAIN,
        CMD_ERASE_ALL,
        CMD_UNLOCK_A,
        CMD_LOCK_A
    } fsep_cmd_t;
    // Controller states
    typedef enum logic [2:0] {
        ST_CAL,
        ST_IDLE,
        ST_EXEC,
        ST_RDATA,
        ST_ERASE
    } fsep_state_t;
    // Decoded flash location
    typedef struct packed {
        logic ok;
        logic info;
        logic seg_a;
        logic [15:0] widx;
        logic [15:0] seg_first;
        logic [15:0] seg_last;
    } fsep_loc_t;
endpackage : fsep_pkg

// File: design/fsep_mem_if.sv
`timescale 1ns/1ns
`default_nettype none
interface fsep_mem_if #(parameter int AW = 14);
    logic we; // Write strobe
    logic [1:0] be; // Byte lanes
    logic [AW-1:0] addr; // Word index
    logic [15:0] wdata; // Write word
    logic [15:0] rdata; // Registered read word
    modport ctrl (output we, be, addr, wdata, input rdata);
    modport mem (input we, be, addr, wdata, output rdata);
endinterface : fsep_mem_if
`default_nettype wire

// File: design/fsep_mem.sv
`timescale 1ns/1ns
`default_nettype none
`include "fsep_cfg.svh"
module fsep_mem #(
    parameter int DEPTH = 8320,
    parameter int AW = 14
) (
    input wire logic clk_in,
    fsep_mem_if.mem bus
);
    // One byte array per lane
    genvar g;
    generate
        for (g = 0; g < 2; g++) begin : g_lane
            // Array starts erased, like a blank part; no process writes it but the lane
            logic [7:0] arr [DEPTH] = '{default: 8'(`FSEP_ERASED_WORD >> (8 * g))};
            logic [7:0] rd_q; // Registered lane read
            // Lane write and registered read
            always_ff @(posedge clk_in) begin
                if (bus.we && bus.be[g]) begin
                    arr[bus.addr] <= bus.wdata[8*g +: 8];
                end
                rd_q <= arr[bus.addr];
            end
        end
    endgenerate
    // One driver for the shared read word, both lanes joined here
    assign bus.rdata = {g_lane[1].rd_q, g_lane[0].rd_q};
endmodule : fsep_mem
`default_nettype wire

// File: design/fsep_ctrl.sv
// Operation
// - Program from debug port and CPU
// - CPU writes single bytes and words
// - Four info segments A-D, 64 bytes
// - Main segments 512 bytes, erase unit
// - Erase all main or one segment
// - Info segments erased alone or with main
// - Segment A locked after every reset
// - Segment A lock can be released
// - Calibration kept as tag-length-value records
// - Oscillator tag 0x01 at 0x10F6; converter 0x08
// - Tag 0xFE marks an empty area
// - Oscillator frequency and range bytes per point
// - Converter offset at 4, gain at 2
`timescale 1ns/1ns
`default_nettype none
`include "fsep_cfg.svh"
module fsep_ctrl #(
    parameter int MAIN_SEGS = `FSEP_MAIN_SEGS_DEF
) (
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic cpu_req_in,
    input wire fsep_pkg::fsep_cmd_t cpu_cmd_in,
    input wire logic [15:0] cpu_addr_in,
    input wire logic [15:0] cpu_wdata_in,
    output logic cpu_ready_out,
    input wire logic dbg_req_in,
    input wire fsep_pkg::fsep_cmd_t dbg_cmd_in,
    input wire logic [15:0] dbg_addr_in,
    input wire logic [15:0] dbg_wdata_in,
    output logic dbg_ready_out,
    output logic done_out,
    output logic err_out,
    output logic done_dbg_out,
    output logic [15:0] rdata_out,
    output logic seg_a_locked_out,
    output logic osc_cal_valid_out,
    output logic [7:0] osc_freq_setting_low_out,
    output logic [7:0] osc_range_setting_low_out,
    output logic converter_cal_valid_out,
    output logic [15:0] converter_gain_word_out,
    output logic [15:0] converter_offset_word_out
);
    // Geometry in 16-bit words
    localparam int INFO_SEG_WORDS = int'(`FSEP_INFO_SEG_BYTES) / 2;
    localparam int INFO_WORDS = INFO_SEG_WORDS * int'(`FSEP_INFO_SEGS);
    localparam int MAIN_SEG_WORDS = int'(`FSEP_MAIN_SEG_BYTES) / 2;
    localparam int DEPTH = INFO_WORDS + MAIN_SEGS * MAIN_SEG_WORDS;
    localparam int AW = $clog2(DEPTH);
    localparam logic [15:0] INFO_W16 = 16'(INFO_WORDS);
    localparam logic [15:0] ISEG_W = 16'(INFO_SEG_WORDS);
    localparam logic [15:0] MSEG_W = 16'(MAIN_SEG_WORDS);
    localparam logic [15:0] LAST_W = 16'(DEPTH - 1);
    localparam logic [16:0] MAIN_LO = 17'(32'h0001_0000 - MAIN_SEGS * 2 * MAIN_SEG_WORDS);
    localparam logic [15:0] A_FIRST = 16'(int'(`FSEP_SEG_A_IDX) * INFO_SEG_WORDS);
    localparam logic [15:0] A_LAST = A_FIRST + ISEG_W - 16'h0001;

    // Byte address to word index and segment bounds
    function automatic fsep_pkg::fsep_loc_t loc(input logic [15:0] a);
        fsep_pkg::fsep_loc_t l;
        logic [16:0] rel;
        l = '0;
        rel = '0;
        if (a >= `FSEP_INFO_BASE && a < `FSEP_INFO_BASE + 16'(INFO_WORDS * 2)) begin
            // Information memory, four 64-byte segments
            rel = {1'b0, a - `FSEP_INFO_BASE};
            l.ok = 1'b1;
            l.info = 1'b1;
            l.widx = rel[16:1];
            l.seg_first = rel[16:1] & ~(ISEG_W - 16'h0001);
            l.seg_last = l.seg_first + ISEG_W - 16'h0001;
            l.seg_a = (a[7:6] == `FSEP_SEG_A_IDX);
        end else if ({1'b0, a} >= MAIN_LO) begin
            // Main memory, 512-byte segments
            rel = {1'b0, a} - MAIN_LO;
            l.ok = 1'b1;
            l.widx = INFO_W16 + rel[16:1];
            l.seg_first = INFO_W16 + (rel[16:1] & ~(MSEG_W - 16'h0001));
            l.seg_last = l.seg_first + MSEG_W - 16'h0001;
        end
        return l;
    endfunction : loc

    // Word index of a calibration read step
    function automatic logic [15:0] cal_widx(input logic [2:0] s);
        logic [15:0] a;
        fsep_pkg::fsep_loc_t l;
        case (s)
            3'h0: a = `FSEP_OSC_TAG_ADDR;
            3'h1: a = `FSEP_OSC_TAG_ADDR + `FSEP_OSC_PAIR_OFS;
            3'h2: a = `FSEP_CONV_TAG_ADDR;
            3'h3: a = `FSEP_CONV_TAG_ADDR + `FSEP_CONV_GAIN_OFS;
            default: a = `FSEP_CONV_TAG_ADDR + `FSEP_CONV_OFFSET_OFS;
        endcase
        l = loc(a);
        return l.widx;
    endfunction : cal_widx

    fsep_mem_if #(.AW(AW)) mif ();
    fsep_mem #(.DEPTH(DEPTH), .AW(AW)) u_mem (.clk_in(clk_in), .bus(mif));

    fsep_pkg::fsep_state_t state_q; // Controller state
    fsep_pkg::fsep_cmd_t cmd_q; // Held command
    logic [15:0] addr_q; // Held byte address
    logic [15:0] wdata_q; // Held write data
    logic src_dbg_q; // Request came from debug port
    logic lock_q; // Segment A lock
    logic [2:0] cal_step_q; // Calibration read step
    logic [15:0] erase_ptr_q; // Next word to erase
    logic [15:0] erase_end_q; // Last word to erase
    logic done_q, err_q; // Completion pulses
    logic [15:0] rdata_q; // Read result
    logic osc_valid_q, conv_valid_q;
    logic [7:0] osc_freq_q, osc_range_q;
    logic [15:0] conv_gain_q, conv_offset_q;
    fsep_pkg::fsep_loc_t xl; // Decode of held address
    logic exec_bad; // Held request refused
    logic erase_skip; // Erase pointer inside locked A
    logic take_dbg, take_cpu;

    // Debug port wins when both ask
    assign dbg_ready_out = (state_q == fsep_pkg::ST_IDLE);
    assign cpu_ready_out = (state_q == fsep_pkg::ST_IDLE) && !dbg_req_in;
    assign take_dbg = dbg_req_in && dbg_ready_out;
    assign take_cpu = cpu_req_in && cpu_ready_out;

    // Refusals: unmapped, odd word, locked segment A
    always_comb begin
        xl = loc(addr_q);
        exec_bad = 1'b0;
        case (cmd_q)
            fsep_pkg::CMD_READ: exec_bad = !xl.ok;
            fsep_pkg::CMD_WRITE_BYTE: exec_bad = !xl.ok || (xl.seg_a && lock_q);
            fsep_pkg::CMD_WRITE_WORD: exec_bad = !xl.ok || addr_q[0] || (xl.seg_a && lock_q);
            fsep_pkg::CMD_ERASE_SEG: exec_bad = !xl.ok || (xl.seg_a && lock_q);
            default: exec_bad = 1'b0;
        endcase
        erase_skip = lock_q && erase_ptr_q >= A_FIRST && erase_ptr_q <= A_LAST;
    end

    // Memory port steering
    always_comb begin
        mif.we = 1'b0;
        mif.be = 2'b11;
        mif.addr = AW'(xl.widx);
        mif.wdata = wdata_q;
        case (state_q)
            fsep_pkg::ST_CAL: mif.addr = AW'(cal_widx(cal_step_q));
            fsep_pkg::ST_EXEC: begin
                if (!exec_bad && cmd_q == fsep_pkg::CMD_WRITE_BYTE) begin
                    // Byte lands on the lane chosen by address bit 0
                    mif.we = 1'b1;
                    mif.be = addr_q[0] ? 2'b10 : 2'b01;
                    mif.wdata = {wdata_q[7:0], wdata_q[7:0]};
                end else if (!exec_bad && cmd_q == fsep_pkg::CMD_WRITE_WORD) begin
                    mif.we = 1'b1;
                end
            end
            fsep_pkg::ST_ERASE: begin
                mif.addr = AW'(erase_ptr_q);
                mif.we = !erase_skip;
                mif.wdata = `FSEP_ERASED_WORD;
            end
            default: mif.we = 1'b0;
        endcase
    end

    // Sequencing
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            state_q <= fsep_pkg::ST_CAL;
            cal_step_q <= 3'h0;
            cmd_q <= fsep_pkg::CMD_READ;
            addr_q <= 16'h0000;
            wdata_q <= 16'h0000;
            src_dbg_q <= 1'b0;
            erase_ptr_q <= 16'h0000;
            erase_end_q <= 16'h0000;
        end else begin
            case (state_q)
                fsep_pkg::ST_CAL: begin
                    // Five reads, each data one cycle late
                    cal_step_q <= cal_step_q + 3'h1;
                    if (cal_step_q == 3'h5) begin
                        state_q <= fsep_pkg::ST_IDLE;
                    end
                end
                fsep_pkg::ST_IDLE: begin
                    if (take_dbg) begin
                        cmd_q <= dbg_cmd_in;
                        addr_q <= dbg_addr_in;
                        wdata_q <= dbg_wdata_in;
                        src_dbg_q <= 1'b1;
                        state_q <= fsep_pkg::ST_EXEC;
                    end else if (take_cpu) begin
                        cmd_q <= cpu_cmd_in;
                        addr_q <= cpu_addr_in;
                        wdata_q <= cpu_wdata_in;
                        src_dbg_q <= 1'b0;
                        state_q <= fsep_pkg::ST_EXEC;
                    end
                end
                fsep_pkg::ST_EXEC: begin
                    state_q <= fsep_pkg::ST_IDLE;
                    if (!exec_bad) begin
                        case (cmd_q)
                            fsep_pkg::CMD_READ: state_q <= fsep_pkg::ST_RDATA;
                            fsep_pkg::CMD_ERASE_SEG: begin
                                erase_ptr_q <= xl.seg_first;
                                erase_end_q <= xl.seg_last;
                                state_q <= fsep_pkg::ST_ERASE;
                            end
                            fsep_pkg::CMD_ERASE_MAIN: begin
                                erase_ptr_q <= INFO_W16;
                                erase_end_q <= LAST_W;
                                state_q <= fsep_pkg::ST_ERASE;
                            end
                            fsep_pkg::CMD_ERASE_ALL: begin
                                erase_ptr_q <= 16'h0000;
                                erase_end_q <= LAST_W;
                                state_q <= fsep_pkg::ST_ERASE;
                            end
                            default: state_q <= fsep_pkg::ST_IDLE;
                        endcase
                    end
                end
                fsep_pkg::ST_RDATA: state_q <= fsep_pkg::ST_IDLE;
                fsep_pkg::ST_ERASE: begin
                    // One word per clock; long, but no wait states
                    erase_ptr_q <= erase_ptr_q + 16'h0001;
                    if (erase_ptr_q == erase_end_q) begin
                        state_q <= fsep_pkg::ST_IDLE;
                    end
                end
                default: state_q <= fsep_pkg::ST_IDLE;
            endcase
        end
    end

    // Segment A lock, set again by every reset
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            lock_q <= 1'b1;
        end else if (state_q == fsep_pkg::ST_EXEC && cmd_q == fsep_pkg::CMD_UNLOCK_A) begin
            lock_q <= 1'b0;
        end else if (state_q == fsep_pkg::ST_EXEC && cmd_q == fsep_pkg::CMD_LOCK_A) begin
            lock_q <= 1'b1;
        end
    end

    // Completion pulses and read result
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            done_q <= 1'b0;
            err_q <= 1'b0;
            rdata_q <= 16'h0000;
        end else begin
            done_q <= 1'b0;
            err_q <= 1'b0;
            if (state_q == fsep_pkg::ST_EXEC && (exec_bad || (cmd_q != fsep_pkg::CMD_READ
                    && cmd_q != fsep_pkg::CMD_ERASE_SEG && cmd_q != fsep_pkg::CMD_ERASE_MAIN
                    && cmd_q != fsep_pkg::CMD_ERASE_ALL))) begin
                done_q <= 1'b1;
                err_q <= exec_bad;
            end else if (state_q == fsep_pkg::ST_RDATA) begin
                done_q <= 1'b1;
                rdata_q <= mif.rdata;
            end else if (state_q == fsep_pkg::ST_ERASE && erase_ptr_q == erase_end_q) begin
                done_q <= 1'b1;
            end
        end
    end

    // Calibration record capture after reset
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            osc_valid_q <= 1'b0;
            conv_valid_q <= 1'b0;
            osc_freq_q <= 8'h00;
            osc_range_q <= 8'h00;
            conv_gain_q <= 16'h0000;
            conv_offset_q <= 16'h0000;
        end else if (state_q == fsep_pkg::ST_CAL) begin
            case (cal_step_q)
                // Empty tag or a foreign one leaves the record invalid
                3'h1: osc_valid_q <= mif.rdata[7:0] == `FSEP_OSC_TAG
                    && mif.rdata[7:0] != `FSEP_EMPTY_TAG;
                3'h2: begin
                    osc_freq_q <= mif.rdata[7:0];
                    osc_range_q <= mif.rdata[15:8];
                end
                3'h3: conv_valid_q <= mif.rdata[7:0] == `FSEP_CONV_TAG
                    && mif.rdata[7:0] != `FSEP_EMPTY_TAG;
                3'h4: conv_gain_q <= mif.rdata;
                3'h5: conv_offset_q <= mif.rdata;
                default: osc_valid_q <= osc_valid_q;
            endcase
        end
    end

    assign done_out = done_q;
    assign err_out = err_q;
    assign done_dbg_out = done_q && src_dbg_q;
    assign rdata_out = rdata_q;
    assign seg_a_locked_out = lock_q;
    assign osc_cal_valid_out = osc_valid_q;
    assign osc_freq_setting_low_out = osc_freq_q;
    assign osc_range_setting_low_out = osc_range_q;
    assign converter_cal_valid_out = conv_valid_q;
    assign converter_gain_word_out = conv_gain_q;
    assign converter_offset_word_out = conv_offset_q;

    default clocking cb @(posedge clk_in); endclocking
    default disable iff (rst_in);

    sequence s_exec(fsep_pkg::fsep_cmd_t c);
        state_q == fsep_pkg::ST_EXEC && cmd_q == c && !exec_bad;
    endsequence

    a_dbg_wins_grant: assert property (dbg_req_in |-> !cpu_ready_out)
        else $error("cpu granted while debug asks");
    a_word_write_lanes: assert property (s_exec(fsep_pkg::CMD_WRITE_WORD)
        |-> mif.we && mif.be == 2'b11)
        else $error("word write lanes wrong");
    a_byte_write_lane: assert property (s_exec(fsep_pkg::CMD_WRITE_BYTE)
        |-> mif.we && mif.be == (addr_q[0] ? 2'b10 : 2'b01))
        else $error("byte write lane wrong");
    a_info_seg_span: assert property (s_exec(fsep_pkg::CMD_ERASE_SEG) ##0 xl.info
        |=> erase_end_q - erase_ptr_q == 16'h001f)
        else $error("info segment span wrong");
    a_main_seg_span: assert property (s_exec(fsep_pkg::CMD_ERASE_SEG) ##0 !xl.info
        |=> erase_end_q - erase_ptr_q == 16'h00ff && erase_ptr_q >= INFO_W16)
        else $error("main segment span wrong");
    a_mass_main_range: assert property (s_exec(fsep_pkg::CMD_ERASE_MAIN)
        |=> erase_ptr_q == INFO_W16 && erase_end_q == LAST_W)
        else $error("main mass erase range wrong");
    a_mass_all_range: assert property (s_exec(fsep_pkg::CMD_ERASE_ALL)
        |=> erase_ptr_q == 16'h0000 ##1 state_q == fsep_pkg::ST_ERASE)
        else $error("full mass erase range wrong");
    a_lock_after_reset: assert property ($past(rst_in) |-> lock_q && seg_a_locked_out)
        else $error("segment A not locked after reset");
    a_unlock_takes: assert property (s_exec(fsep_pkg::CMD_UNLOCK_A)
        |=> !lock_q && done_out)
        else $error("unlock did not take");
    a_osc_tag_check: assert property (state_q == fsep_pkg::ST_CAL && cal_step_q == 3'h1
        |=> osc_cal_valid_out == ($past(mif.rdata[7:0]) == 8'h01))
        else $error("oscillator tag check wrong");
    a_seg_a_guard: assert property (mif.we && lock_q
        |-> !(16'(mif.addr) >= A_FIRST && 16'(mif.addr) <= A_LAST))
        else $error("write reached locked segment A");
    a_locked_refused: assert property (state_q == fsep_pkg::ST_EXEC && lock_q && xl.seg_a
        && cmd_q == fsep_pkg::CMD_WRITE_WORD |=> err_out && done_out)
        else $error("locked write not refused");
endmodule : fsep_ctrl
`default_nettype wire

// File: verif/fsep_req_model.sv
`timescale 1ns/1ns
`default_nettype none
// Requester on one programming port, CPU or debug programmer
module fsep_req_model (
    input wire logic clk_in,
    input wire logic ready_in,
    input wire logic done_in,
    input wire logic err_in,
    input wire logic [15:0] rdata_in,
    output logic req_out,
    output var fsep_pkg::fsep_cmd_t cmd_out,
    output logic [15:0] addr_out,
    output logic [15:0] wdata_out
);
    // Idle values at time zero
    initial begin
        req_out = 1'b0;
        cmd_out = fsep_pkg::CMD_READ;
        addr_out = 16'h0000;
        wdata_out = 16'h0000;
    end
    // One request, entered just after a rising edge, left just after the done edge
    task automatic xfer(input fsep_pkg::fsep_cmd_t c, input logic [15:0] a,
                        input logic [15:0] d, output logic e, output logic [15:0] r);
        int n;
        n = 0;
        e = 1'bx;
        r = 16'hxxxx;
        req_out = 1'b1;
        cmd_out = c;
        addr_out = a;
        wdata_out = d;
        // Ready looked at mid-cycle, where it has settled
        @(negedge clk_in);
        while (ready_in !== 1'b1 && n < 100) begin
            @(negedge clk_in);
            n++;
        end
        @(posedge clk_in);
        #1;
        req_out = 1'b0;
        // Released lines carry the inverse, so stale values never pass for data
        addr_out = ~a;
        wdata_out = ~d;
        n = 0;
        // Bounded wait; a timeout leaves unknowns that fail every compare
        while (done_in !== 1'b1 && n < 2000) begin
            @(posedge clk_in);
            #1;
            n++;
        end
        if (done_in === 1'b1) begin
            e = err_in;
            r = rdata_in;
        end
    endtask : xfer
endmodule : fsep_req_model
`default_nettype wire

// File: verif/tb.sv
`timescale 1ns/1ns
`default_nettype none
module tb;
    logic clk_in = 1'b0;
    logic rst_in = 1'b1;
    logic c_req, c_rdy, d_req, d_rdy, done, err, done_dbg, lock, osc_v, conv_v;
    fsep_pkg::fsep_cmd_t c_cmd, d_cmd;
    logic [15:0] c_addr, c_wd, d_addr, d_wd, rdata, gain, ofs;
    logic [7:0] freq, range_set;
    logic e_g; // Last refusal flag
    logic [15:0] r_g; // Last read word
    int n_fail = 0;
    int n_tests = 0;
    // 250 MHz clock
    always #2 clk_in = ~clk_in;
    // Short main memory: two segments from 0xfc00
    fsep_ctrl #(.MAIN_SEGS(2)) fsep_ctrl_i (.clk_in(clk_in), .rst_in(rst_in),
        .cpu_req_in(c_req), .cpu_cmd_in(c_cmd), .cpu_addr_in(c_addr),
        .cpu_wdata_in(c_wd), .cpu_ready_out(c_rdy), .dbg_req_in(d_req),
        .dbg_cmd_in(d_cmd), .dbg_addr_in(d_addr), .dbg_wdata_in(d_wd),
        .dbg_ready_out(d_rdy), .done_out(done), .err_out(err), .done_dbg_out(done_dbg),
        .rdata_out(rdata), .seg_a_locked_out(lock), .osc_cal_valid_out(osc_v),
        .osc_freq_setting_low_out(freq), .osc_range_setting_low_out(range_set),
        .converter_cal_valid_out(conv_v), .converter_gain_word_out(gain),
        .converter_offset_word_out(ofs));
    // CPU side and debug side requesters
    fsep_req_model cpu_m (.clk_in(clk_in), .ready_in(c_rdy), .done_in(done), .err_in(err),
        .rdata_in(rdata), .req_out(c_req), .cmd_out(c_cmd), .addr_out(c_addr),
        .wdata_out(c_wd));
    fsep_req_model dbg_m (.clk_in(clk_in), .ready_in(d_rdy), .done_in(done), .err_in(err),
        .rdata_in(rdata), .req_out(d_req), .cmd_out(d_cmd), .addr_out(d_addr),
        .wdata_out(d_wd));
    // Flag compare
    task automatic chk1(input logic g, input logic x);
        n_tests++;
        if (g !== x) begin
            n_fail++;
            $display("mismatch at %0t: flag %b, expected %b", $time, g, x);
        end
    endtask : chk1
    // Word compare
    task automatic chk16(input logic [15:0] g, input logic [15:0] x);
        n_tests++;
        if (g !== x) begin
            n_fail++;
            $display("mismatch at %0t: word %h, expected %h", $time, g, x);
        end
    endtask : chk16
    // Reset held 8 cycles, then time for the calibration load
    task automatic do_reset();
        rst_in = 1'b1;
        repeat (8) @(posedge clk_in);
        #1 rst_in = 1'b0;
        repeat (8) @(posedge clk_in);
        #1;
    endtask : do_reset
    // One request from either port
    task automatic go(input logic dbg, input fsep_pkg::fsep_cmd_t c, input logic [15:0] a,
                      input logic [15:0] d);
        if (dbg) dbg_m.xfer(c, a, d, e_g, r_g);
        else cpu_m.xfer(c, a, d, e_g, r_g);
    endtask : go
    // Request with the refusal outcome judged
    task automatic wr(input fsep_pkg::fsep_cmd_t c, input logic [15:0] a, input logic [15:0] d,
                      input logic x);
        cpu_m.xfer(c, a, d, e_g, r_g);
        chk1(e_g, x);
    endtask : wr
    // Read with the word judged
    task automatic rd(input logic [15:0] a, input logic [15:0] x);
        cpu_m.xfer(fsep_pkg::CMD_READ, a, 16'h0000, e_g, r_g);
        chk16(r_g, x);
    endtask : rd
    // State after power-up with erased memory
    task automatic t_reset_state();
        chk1(lock, 1'b1);
        chk1(osc_v, 1'b0);
        chk1(conv_v, 1'b0);
    endtask : t_reset_state
    // Word and byte programming from the CPU port, word programming from the debug port
    task automatic t_prog();
        wr(fsep_pkg::CMD_WRITE_WORD, 16'hfc00, 16'h1234, 1'b0);
        rd(16'hfc00, 16'h1234);
        wr(fsep_pkg::CMD_WRITE_BYTE, 16'hfc03, 16'h00ab, 1'b0);
        rd(16'hfc02, 16'habff);
        // Odd word address and unmapped address are refused, memory kept
        wr(fsep_pkg::CMD_WRITE_WORD, 16'hfc01, 16'h5555, 1'b1);
        wr(fsep_pkg::CMD_WRITE_WORD, 16'h2000, 16'h5555, 1'b1);
        rd(16'hfc00, 16'h1234);
        chk1(done_dbg, 1'b0);
        go(1'b1, fsep_pkg::CMD_WRITE_WORD, 16'hfe00, 16'h7777);
        chk1(done_dbg, 1'b1);
        chk1(e_g, 1'b0);
        rd(16'hfe00, 16'h7777);
    endtask : t_prog
    // Segment A lock, unlock and calibration records
    task automatic t_lock();
        wr(fsep_pkg::CMD_WRITE_WORD, 16'h10f6, 16'h0001, 1'b1);
        rd(16'h10f6, 16'hffff);
        wr(fsep_pkg::CMD_ERASE_SEG, 16'h10c0, 16'h0000, 1'b1);
        wr(fsep_pkg::CMD_UNLOCK_A, 16'h10c0, 16'h0000, 1'b0);
        chk1(lock, 1'b0);
        wr(fsep_pkg::CMD_WRITE_WORD, 16'h10f6, 16'h0001, 1'b0);
        wr(fsep_pkg::CMD_WRITE_WORD, 16'h10fe, 16'h5a3c, 1'b0);
        wr(fsep_pkg::CMD_WRITE_WORD, 16'h10da, 16'h00fe, 1'b0);
        wr(fsep_pkg::CMD_WRITE_WORD, 16'h10dc, 16'h1111, 1'b0);
        wr(fsep_pkg::CMD_WRITE_WORD, 16'h10de, 16'h2222, 1'b0);
        do_reset();
        chk1(lock, 1'b1);
        chk1(osc_v, 1'b1);
        chk16({8'h00, freq}, 16'h003c);
        chk16({8'h00, range_set}, 16'h005a);
        chk1(conv_v, 1'b0);
        wr(fsep_pkg::CMD_UNLOCK_A, 16'h10c0, 16'h0000, 1'b0);
        wr(fsep_pkg::CMD_WRITE_WORD, 16'h10da, 16'h0008, 1'b0);
        wr(fsep_pkg::CMD_LOCK_A, 16'h10c0, 16'h0000, 1'b0);
        chk1(lock, 1'b1);
        do_reset();
        chk1(conv_v, 1'b1);
        chk16(gain, 16'h1111);
        chk16(ofs, 16'h2222);
    endtask : t_lock
    // Segment, main and mass erase with boundary words
    task automatic t_erase();
        logic [15:0] ea [5];
        ea = '{16'h1000, 16'h1040, 16'hfc00, 16'hfdfe, 16'hfe00};
        for (int i = 0; i < 5; i++) begin
            wr(fsep_pkg::CMD_WRITE_WORD, ea[i], 16'ha000 + 16'(i), 1'b0);
        end
        wr(fsep_pkg::CMD_ERASE_SEG, 16'h1000, 16'h0000, 1'b0);
        rd(16'h1000, 16'hffff);
        rd(16'h1040, 16'ha001);
        wr(fsep_pkg::CMD_ERASE_SEG, 16'hfc00, 16'h0000, 1'b0);
        rd(16'hfdfe, 16'hffff);
        rd(16'hfe00, 16'ha004);
        wr(fsep_pkg::CMD_ERASE_MAIN, 16'hfc00, 16'h0000, 1'b0);
        rd(16'hfe00, 16'hffff);
        rd(16'h1040, 16'ha001);
        wr(fsep_pkg::CMD_ERASE_ALL, 16'hfc00, 16'h0000, 1'b0);
        rd(16'h1040, 16'hffff);
        rd(16'h10f6, 16'h0001);
    endtask : t_erase
    // Counts, verdict and end of run
    task automatic wrap_up();
        $display("comparisons %0d, mismatches %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask : wrap_up
    // Main sequence
    initial begin
        do_reset();
        t_reset_state();
        t_prog();
        t_lock();
        t_erase();
        wrap_up();
    end
    // Watchdog, well above the expected run of under two thousand cycles
    initial begin
        #200000;
        n_fail++;
        wrap_up();
    end
endmodule : tb
`default_nettype wire
